// File: rtl/ttrb_params.svh
// Offsets, field layouts, reset values and hysteresis counts of the trip register bank
// ==========================================================================
// What this block does
// - Reading holds a 12-bit two's complement value in bits 12:1, 0.125 C steps.
// - Bit 0 of the reading is always zero; bit 11 weighs 128 C, bit 12 is sign.
// - Top three reading bits come only from present trip comparisons, not the event pin.
// - Thresholds keep bits 12:2 in 0.25 C steps; bits 15:13 and 1:0 read zero.
// - Comparisons always use the thresholds as programmed right now.
// - Critical flag sets at or above critical; clears below critical minus hysteresis.
// - Over-window flag sets above upper; clears at or below upper minus hysteresis.
// - Under-window flag clears at or above lower; sets below lower minus hysteresis.
// - Reading sign bit is 0 for positive and 1 for negative values.
// - Read-only identity word: part code high byte, revision low byte; writes ignored.
// - Bus control bit 7 turns the bus time-out off; reset value 0 keeps it on.
// - Time-out disable bit ignores writes while either lock bit is set.
// - Bus control resets with bits 5, 4 and 0 set, others clear, reserved zero.
// - Hysteresis select: 00 none, 01 1.5 C, 10 3 C, 11 6 C; resets to 00.
// - All three trip flags clear when the sensor enters shutdown.
// - Lock bits once set stay set and read as 1 until power-on reset.
`ifndef TTRB_PARAMS_SVH
`define TTRB_PARAMS_SVH

// ==========================================================================
// Register offsets
`define TTRB_OFS_UPPER      8'h02
`define TTRB_OFS_LOWER      8'h03
`define TTRB_OFS_CRIT       8'h04
`define TTRB_OFS_READING    8'h05
`define TTRB_OFS_MAKER      8'h06
`define TTRB_OFS_PART       8'h07
`define TTRB_OFS_BUSCTL     8'h22

// ==========================================================================
// Field layouts and reset values
`define TTRB_THR_MASK       16'h1ffc
`define TTRB_THR_RESET      16'h0000
`define TTRB_BUSCTL_WMASK   8'hbd
`define TTRB_BUSCTL_RESET   8'h31
`define TTRB_BIT_GUARD_OFF  7
`define TTRB_BIT_SLEEP_TO   5
`define TTRB_BIT_SLEEP_EVT  4
`define TTRB_BIT_CLR_POL    3
`define TTRB_BIT_FLAG_UPD   2
`define TTRB_BIT_ARA_OFF    0

// ==========================================================================
// Hysteresis in 0.125 C steps
`define TTRB_HYS_NONE       14'sd0
`define TTRB_HYS_1P5        14'sd12
`define TTRB_HYS_3          14'sd24
`define TTRB_HYS_6          14'sd48

// ==========================================================================
// Handshake bound, link clock cycles
`define TTRB_ACK_MAX_LINK   20

`endif

// File: rtl/ttrb_pkg.sv
// Types shared by the trip register bank modules
`default_nettype none
package ttrb_pkg;

    typedef logic signed [11:0] ttrb_temp_type;
    typedef logic signed [13:0] ttrb_wide_type;

    typedef enum logic [1:0] {
        TTRB_LINK_IDLE = 2'b01,
        TTRB_LINK_WAIT = 2'b10
    } ttrb_link_state_type;

endpackage
`default_nettype wire

// File: rtl/ttrb_trip_flags.sv
// Trip comparators with hysteresis for the critical and window flags
`timescale 1ns/1ps
`default_nettype none
`include "ttrb_params.svh"

module ttrb_trip_flags (
    input  wire logic                    clk_sys_i,            // System clock
    input  wire logic                    sys_rst_i,            // Sync reset, high
    input  wire ttrb_pkg::ttrb_temp_type temp_i,               // Reading, 0.125 C steps
    input  wire logic [15:0]             upper_i,              // Upper threshold word
    input  wire logic [15:0]             lower_i,              // Lower threshold word
    input  wire logic [15:0]             crit_i,               // Critical threshold word
    input  wire logic [1:0]              hysteresis_select_i,  // Hysteresis code
    input  wire logic                    sensor_shutdown_i,    // Sensor in shutdown
    input  wire logic                    eval_i,               // Compare this cycle
    output logic                         over_critical_flag_o, // Critical trip
    output logic                         over_window_flag_o,   // Above window
    output logic                         under_window_flag_o   // Below window
);
    import ttrb_pkg::*;

    logic          next_crit;
    logic          next_over;
    logic          next_under;
    ttrb_wide_type hys;
    ttrb_wide_type t_w;
    ttrb_wide_type u_w;
    ttrb_wide_type l_w;
    ttrb_wide_type c_w;

    function automatic ttrb_wide_type align_thr(input logic [15:0] raw);
        align_thr = ttrb_wide_type'($signed({raw[12:2], 1'b0}));
    endfunction

    // ==========================================================================
    // Comparison
    always_comb begin
        unique case (hysteresis_select_i)
            2'b00: hys = `TTRB_HYS_NONE;
            2'b01: hys = `TTRB_HYS_1P5;
            2'b10: hys = `TTRB_HYS_3;
            2'b11: hys = `TTRB_HYS_6;
        endcase
        t_w        = ttrb_wide_type'(temp_i);
        u_w        = align_thr(upper_i);
        l_w        = align_thr(lower_i);
        c_w        = align_thr(crit_i);
        next_crit  = over_critical_flag_o;
        next_over  = over_window_flag_o;
        next_under = under_window_flag_o;
        if (sensor_shutdown_i) begin
            next_crit  = 1'b0;
            next_over  = 1'b0;
            next_under = 1'b0;
        end else if (eval_i) begin
            // Held crit and over flags move their edge down by the hysteresis; under sets below lower minus it
            next_crit  = over_critical_flag_o ? (t_w >= c_w - hys) : (t_w >= c_w);
            next_over  = over_window_flag_o ? (t_w > u_w - hys) : (t_w > u_w);
            next_under = under_window_flag_o ? (t_w < l_w) : (t_w < l_w - hys);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            over_critical_flag_o <= 1'b0;
            over_window_flag_o   <= 1'b0;
            under_window_flag_o  <= 1'b0;
        end else begin
            over_critical_flag_o <= next_crit;
            over_window_flag_o   <= next_over;
            under_window_flag_o  <= next_under;
        end
    end

    // ==========================================================================
    // Checks
    property p_shutdown_clears;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        sensor_shutdown_i |=> !over_critical_flag_o && !over_window_flag_o
                              && !under_window_flag_o;
    endproperty
    a_shutdown_clears: assert property (p_shutdown_clears)
        else $error("trip flags not cleared in shutdown");

    property p_crit_rise;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!sensor_shutdown_i && eval_i && !over_critical_flag_o && t_w < c_w)
            |=> !over_critical_flag_o;
    endproperty
    a_crit_rise: assert property (p_crit_rise)
        else $error("critical flag set below threshold");

    property p_over_hold;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!sensor_shutdown_i && eval_i && over_window_flag_o && t_w > u_w - hys)
            |=> over_window_flag_o;
    endproperty
    a_over_hold: assert property (p_over_hold)
        else $error("window flag dropped inside hysteresis");

    property p_under_rise;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (!sensor_shutdown_i && eval_i && t_w >= l_w) |=> !under_window_flag_o;
    endproperty
    a_under_rise: assert property (p_under_rise)
        else $error("under flag held at or above lower");

endmodule
`default_nettype wire

// File: rtl/ttrb_register_bank.sv
// Temperature reading, trip thresholds, identity and bus control registers
`timescale 1ns/1ps
`default_nettype none
`include "ttrb_params.svh"

module ttrb_register_bank #(
    parameter logic [15:0] MAKER_CODE = 16'h5a5a, // Arbitrary value
    parameter logic [7:0]  PART_CODE  = 8'h3c,    // Arbitrary value
    parameter logic [7:0]  REV_CODE   = 8'h01     // Arbitrary value
) (
    input  wire logic                    clk_sys_i,              // System clock
    input  wire logic                    sys_rst_i,              // Sync reset, high
    input  wire ttrb_pkg::ttrb_temp_type temp_code_i,            // Converter result
    input  wire logic                    temp_valid_i,           // New result pulse
    input  wire logic [1:0]              hysteresis_select_i,    // Hysteresis code
    input  wire logic                    sensor_shutdown_i,      // Sensor shut down
    input  wire logic                    critical_lock_set_i,    // Set critical lock
    input  wire logic                    window_lock_set_i,      // Set window lock
    output logic                         critical_lock_o,        // Critical lock state
    output logic                         window_lock_o,          // Window lock state
    output logic                         over_critical_flag_o,   // Critical trip
    output logic                         over_window_flag_o,     // Above window
    output logic                         under_window_flag_o,    // Below window
    output logic                         bus_stall_guard_off_o,  // Time-out off
    output logic                         sleep_stall_guard_on_o, // Time-out in sleep
    output logic                         event_sleep_deassert_o, // Event idle in sleep
    output logic                         comparator_flop_clear_policy_o, // Clear policy
    output logic                         alert_response_off_o,   // Alert response off
    input  wire logic                    clk_link_i,             // Link clock
    input  wire logic                    reg_req_i,              // Access request pulse
    input  wire logic [7:0]              reg_addr_i,             // Register offset
    input  wire logic                    reg_we_i,               // Write when high
    input  wire logic [15:0]             reg_wdata_i,            // Full write word
    output logic                         reg_busy_o,             // Access in flight
    output logic                         reg_ack_o,              // Access done pulse
    output logic [15:0]                  reg_rdata_o             // Read word
);
    import ttrb_pkg::*;

    // ==========================================================================
    // Link side: capture, toggle handshake, return read word
    ttrb_link_state_type link_state;
    ttrb_link_state_type next_link_state;
    logic        link_rst_meta;
    logic        link_rst;
    logic        req_tgl;
    logic        next_req_tgl;
    logic [7:0]  hold_addr;
    logic [7:0]  next_hold_addr;
    logic        hold_we;
    logic        next_hold_we;
    logic [15:0] hold_wdata;
    logic [15:0] next_hold_wdata;
    logic        ack_meta;
    logic        ack_sync;
    logic        ack_seen;
    logic        next_ack;
    logic [15:0] next_rdata_o;

    // Sys side state
    logic        req_meta;
    logic        req_sync;
    logic        req_seen;
    logic        req_edge;
    logic        ack_tgl;
    logic        next_ack_tgl;
    logic [15:0] sys_rdata;
    logic [15:0] next_sys_rdata;
    logic [15:0] upper_thr;
    logic [15:0] next_upper_thr;
    logic [15:0] lower_thr;
    logic [15:0] next_lower_thr;
    logic [15:0] crit_thr;
    logic [15:0] next_crit_thr;
    logic [7:0]  bus_ctl;
    logic [7:0]  next_bus_ctl;
    ttrb_temp_type temp_q;
    ttrb_temp_type next_temp_q;
    logic        sample_new;
    logic        next_sample_new;
    logic        next_crit_lock;
    logic        next_win_lock;
    logic        any_lock;

    assign reg_busy_o = (link_state == TTRB_LINK_WAIT);

    always_comb begin
        next_link_state = link_state;
        next_req_tgl    = req_tgl;
        next_hold_addr  = hold_addr;
        next_hold_we    = hold_we;
        next_hold_wdata = hold_wdata;
        next_ack        = 1'b0;
        next_rdata_o    = reg_rdata_o;
        unique case (link_state)
            TTRB_LINK_IDLE: begin
                if (reg_req_i) begin
                    next_hold_addr  = reg_addr_i;
                    next_hold_we    = reg_we_i;
                    // Whole word taken at once, never a half
                    next_hold_wdata = reg_wdata_i;
                    next_req_tgl    = ~req_tgl;
                    next_link_state = TTRB_LINK_WAIT;
                end
            end
            TTRB_LINK_WAIT: begin
                if (ack_sync != ack_seen) begin
                    // Sys word is stable from the edge that toggled the ack
                    next_rdata_o    = sys_rdata;
                    next_ack        = 1'b1;
                    next_link_state = TTRB_LINK_IDLE;
                end
            end
            default: next_link_state = TTRB_LINK_IDLE;
        endcase
    end

    always_ff @(posedge clk_link_i) begin
        link_rst_meta <= sys_rst_i;
        link_rst      <= link_rst_meta;
        ack_meta      <= ack_tgl;
        ack_sync      <= ack_meta;
        if (link_rst) begin
            link_state  <= TTRB_LINK_IDLE;
            req_tgl     <= 1'b0;
            hold_addr   <= 8'h00;
            hold_we     <= 1'b0;
            hold_wdata  <= 16'h0000;
            ack_seen    <= 1'b0;
            reg_ack_o   <= 1'b0;
            reg_rdata_o <= 16'h0000;
        end else begin
            link_state  <= next_link_state;
            req_tgl     <= next_req_tgl;
            hold_addr   <= next_hold_addr;
            hold_we     <= next_hold_we;
            hold_wdata  <= next_hold_wdata;
            ack_seen    <= ack_sync;
            reg_ack_o   <= next_ack;
            reg_rdata_o <= next_rdata_o;
        end
    end

    // ==========================================================================
    // Sys side: read mux and register writes
    function automatic logic [15:0] read_word(input logic [7:0] a);
        unique case (a)
            `TTRB_OFS_UPPER:   read_word = upper_thr;
            `TTRB_OFS_LOWER:   read_word = lower_thr;
            `TTRB_OFS_CRIT:    read_word = crit_thr;
            // Trip bits are the live comparator outputs only
            `TTRB_OFS_READING: read_word = {over_critical_flag_o, over_window_flag_o,
                                            under_window_flag_o, temp_q, 1'b0};
            `TTRB_OFS_MAKER:   read_word = MAKER_CODE;
            `TTRB_OFS_PART:    read_word = {PART_CODE, REV_CODE};
            `TTRB_OFS_BUSCTL:  read_word = {8'h00, bus_ctl};
            default:           read_word = 16'h0000;
        endcase
    endfunction

    assign req_edge = req_sync ^ req_seen;
    assign any_lock = critical_lock_o | window_lock_o;

    always_comb begin
        next_ack_tgl    = ack_tgl;
        next_sys_rdata  = sys_rdata;
        next_upper_thr  = upper_thr;
        next_lower_thr  = lower_thr;
        next_crit_thr   = crit_thr;
        next_bus_ctl    = bus_ctl;
        next_temp_q     = temp_q;
        next_sample_new = 1'b0;
        // Locks are sticky: only reset clears them
        next_crit_lock  = critical_lock_o | critical_lock_set_i;
        next_win_lock   = window_lock_o | window_lock_set_i;
        if (temp_valid_i && !sensor_shutdown_i) begin
            next_temp_q     = temp_code_i;
            next_sample_new = 1'b1;
        end
        if (req_edge) begin
            next_ack_tgl   = ~ack_tgl;
            next_sys_rdata = read_word(hold_addr);
            if (hold_we) begin
                if (hold_addr == `TTRB_OFS_UPPER && !window_lock_o) begin
                    next_upper_thr = hold_wdata & `TTRB_THR_MASK;
                end
                if (hold_addr == `TTRB_OFS_LOWER && !window_lock_o) begin
                    next_lower_thr = hold_wdata & `TTRB_THR_MASK;
                end
                if (hold_addr == `TTRB_OFS_CRIT && !critical_lock_o) begin
                    next_crit_thr = hold_wdata & `TTRB_THR_MASK;
                end
                if (hold_addr == `TTRB_OFS_BUSCTL && !any_lock) begin
                    next_bus_ctl = hold_wdata[7:0] & `TTRB_BUSCTL_WMASK;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        req_meta <= req_tgl;
        req_sync <= req_meta;
        if (sys_rst_i) begin
            req_seen        <= 1'b0;
            ack_tgl         <= 1'b0;
            sys_rdata       <= 16'h0000;
            upper_thr       <= `TTRB_THR_RESET;
            lower_thr       <= `TTRB_THR_RESET;
            crit_thr        <= `TTRB_THR_RESET;
            bus_ctl         <= `TTRB_BUSCTL_RESET;
            temp_q          <= '0;
            sample_new      <= 1'b0;
            critical_lock_o <= 1'b0;
            window_lock_o   <= 1'b0;
        end else begin
            req_seen        <= req_sync;
            ack_tgl         <= next_ack_tgl;
            sys_rdata       <= next_sys_rdata;
            upper_thr       <= next_upper_thr;
            lower_thr       <= next_lower_thr;
            crit_thr        <= next_crit_thr;
            bus_ctl         <= next_bus_ctl;
            temp_q          <= next_temp_q;
            sample_new      <= next_sample_new;
            critical_lock_o <= next_crit_lock;
            window_lock_o   <= next_win_lock;
        end
    end

    assign bus_stall_guard_off_o          = bus_ctl[`TTRB_BIT_GUARD_OFF];
    assign sleep_stall_guard_on_o         = bus_ctl[`TTRB_BIT_SLEEP_TO];
    assign event_sleep_deassert_o         = bus_ctl[`TTRB_BIT_SLEEP_EVT];
    assign comparator_flop_clear_policy_o = bus_ctl[`TTRB_BIT_CLR_POL];
    assign alert_response_off_o           = bus_ctl[`TTRB_BIT_ARA_OFF];

    // ==========================================================================
    // Trip flags; live thresholds feed the comparators directly
    ttrb_trip_flags u_flags (
        .clk_sys_i            (clk_sys_i),
        .sys_rst_i            (sys_rst_i),
        .temp_i               (temp_q),
        .upper_i              (upper_thr),
        .lower_i              (lower_thr),
        .crit_i               (crit_thr),
        .hysteresis_select_i  (hysteresis_select_i),
        .sensor_shutdown_i    (sensor_shutdown_i),
        .eval_i               (!bus_ctl[`TTRB_BIT_FLAG_UPD] | sample_new),
        .over_critical_flag_o (over_critical_flag_o),
        .over_window_flag_o   (over_window_flag_o),
        .under_window_flag_o  (under_window_flag_o)
    );

    // ==========================================================================
    // Checks
    localparam int ACK_MAX = `TTRB_ACK_MAX_LINK;

    sequence s_req_taken;
        (link_state == TTRB_LINK_IDLE) && reg_req_i;
    endsequence

    sequence s_ack_back;
        ##[1:ACK_MAX] reg_ack_o;
    endsequence

    property p_ack_bounded;
        @(posedge clk_link_i) disable iff (link_rst)
        s_req_taken |-> s_ack_back;
    endproperty
    a_ack_bounded: assert property (p_ack_bounded)
        else $error("register access not acknowledged in time");

    property p_reading_bit0;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_edge && hold_addr == `TTRB_OFS_READING) |=>
            sys_rdata[0] == 1'b0 && sys_rdata[12:1] == $past(temp_q);
    endproperty
    a_reading_bit0: assert property (p_reading_bit0)
        else $error("reading word malformed");

    property p_reading_flags;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_edge && hold_addr == `TTRB_OFS_READING) |=>
            sys_rdata[15:13] == $past({over_critical_flag_o, over_window_flag_o,
                                       under_window_flag_o});
    endproperty
    a_reading_flags: assert property (p_reading_flags)
        else $error("reading trip bits not from comparators");

    property p_thr_reserved;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ((upper_thr | lower_thr | crit_thr) & ~`TTRB_THR_MASK) == 16'h0000;
    endproperty
    a_thr_reserved: assert property (p_thr_reserved)
        else $error("threshold reserved bits set");

    property p_ctl_locked;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        any_lock |=> $stable(bus_ctl);
    endproperty
    a_ctl_locked: assert property (p_ctl_locked)
        else $error("bus control changed while locked");

    property p_lock_sticky;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        critical_lock_o |=> critical_lock_o [*8];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("critical lock released without reset");

    property p_ctl_reset;
        @(posedge clk_sys_i)
        sys_rst_i |=> bus_ctl == `TTRB_BUSCTL_RESET && !bus_stall_guard_off_o;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset)
        else $error("bus control reset value wrong");

    property p_ident;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_edge && hold_addr == `TTRB_OFS_PART) |=> sys_rdata == {PART_CODE, REV_CODE};
    endproperty
    a_ident: assert property (p_ident)
        else $error("identity word wrong");

endmodule
`default_nettype wire

// File: verification/ttrb_host_model.sv
// Host model issuing whole-word register accesses on the link side
`timescale 1ns/1ps
`default_nettype none
module ttrb_host_model (
    input  wire logic        clk_link_i, // Link clock
    input  wire logic        ack_i,      // Access done pulse
    input  wire logic [15:0] rdata_i,    // Read word
    output logic             req_o,      // Request pulse
    output logic [7:0]       addr_o,     // Register offset
    output logic             we_o,       // Write when high
    output logic [15:0]      wdata_o     // Write word
);
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 16'h0000;
    end
    // Both bytes always travel together in one request
    task automatic access(input logic [7:0] a, input logic w, input logic [15:0] d,
                          output logic [15:0] q);
        int n;
        n = 0;
        @(negedge clk_link_i);
        addr_o = a;
        we_o = w;
        wdata_o = d;
        req_o = 1'b1;
        @(negedge clk_link_i);
        req_o = 1'b0;
        do begin
            @(posedge clk_link_i);
            n++;
        end while (ack_i !== 1'b1 && n < 40);
        q = (ack_i === 1'b1) ? rdata_i : 16'hxxxx;
        @(negedge clk_link_i);
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the trip register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ttrb_pkg::*;
    logic          clk_sys_i = 1'b0, clk_link_i = 1'b0, sys_rst_i = 1'b1;
    ttrb_temp_type temp = 12'h000;
    logic          tv = 1'b0, shd = 1'b0, cls = 1'b0, wls = 1'b0, lc, lw, fc, fo, fu, goff;
    logic [1:0]    hys = 2'b00;
    logic          req, we, ack, busy;
    logic [3:0]    ctl;
    logic [7:0]    addr;
    logic [15:0]   wd, rd, q;
    int            miscompares = 0, checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    initial #3 forever #16 clk_link_i = ~clk_link_i;
    ttrb_register_bank u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .temp_code_i(temp), .temp_valid_i(tv), .hysteresis_select_i(hys),
        .sensor_shutdown_i(shd), .critical_lock_set_i(cls), .window_lock_set_i(wls),
        .critical_lock_o(lc), .window_lock_o(lw), .over_critical_flag_o(fc),
        .over_window_flag_o(fo), .under_window_flag_o(fu), .bus_stall_guard_off_o(goff),
        .sleep_stall_guard_on_o(ctl[3]), .event_sleep_deassert_o(ctl[2]),
        .comparator_flop_clear_policy_o(ctl[1]), .alert_response_off_o(ctl[0]),
        .clk_link_i(clk_link_i), .reg_req_i(req), .reg_addr_i(addr), .reg_we_i(we),
        .reg_wdata_i(wd), .reg_busy_o(busy), .reg_ack_o(ack), .reg_rdata_o(rd));
    ttrb_host_model u_host (.clk_link_i(clk_link_i), .ack_i(ack), .rdata_i(rd),
        .req_o(req), .addr_o(addr), .we_o(we), .wdata_o(wd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        u_host.access(a, 1'b0, 16'h0000, q);
        chk(q, e);
    endtask
    // A write that never gets its ack counts as a mismatch
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.access(a, 1'b1, d, q);
        checks++;
        if ($isunknown(q)) begin
            miscompares++;
            $display("CHECK FAILED at %0t: write to %h not acknowledged", $time, a);
        end
    endtask
    // Load a conversion, then give the comparators time to settle
    task automatic heat(input logic [11:0] t, input logic [15:0] e);
        @(negedge clk_sys_i);
        temp = t;
        tv = 1'b1;
        @(negedge clk_sys_i);
        tv = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk({13'h0000, fc, fo, fu}, e);
    endtask
    task automatic t_regs;
        rd_chk(8'h22, 16'h0031);
        chk({15'h0000, goff}, 16'h0000);
        chk({11'h000, busy, ctl}, 16'h000d);
        wr(8'h07, 16'h1234);
        rd_chk(8'h07, 16'h3c01);
        wr(8'h02, 16'hffff);
        rd_chk(8'h02, 16'h1ffc);
        wr(8'h22, 16'h00ff);
        rd_chk(8'h22, 16'h00bd);
        chk({15'h0000, goff}, 16'h0001);
        chk({11'h000, busy, ctl}, 16'h000f);
        $display("test regs done");
    endtask
    task automatic t_flags;
        // Boundaries move only between conversions, no event consumer live
        wr(8'h02, 16'h0190);
        wr(8'h03, 16'h0000);
        wr(8'h04, 16'h07c0);
        heat(12'h0ce, 16'h0002);
        rd_chk(8'h05, 16'h419c);
        heat(12'hf32, 16'h0001);
        rd_chk(8'h05, 16'h3e64);
        wr(8'h04, 16'h0190);
        heat(12'h0c8, 16'h0004);
        hys = 2'b01;
        heat(12'h0ce, 16'h0006);
        heat(12'h0bd, 16'h0006);
        heat(12'h0bc, 16'h0004);
        heat(12'h0bb, 16'h0000);
        heat(12'hff4, 16'h0000);
        heat(12'hff3, 16'h0001);
        heat(12'hfff, 16'h0001);
        shd = 1'b1;
        heat(12'hfff, 16'h0000);
        shd = 1'b0;
        hys = 2'b11;
        heat(12'h0c9, 16'h0006);
        heat(12'h098, 16'h0004);
        hys = 2'b10;
        heat(12'h0b0, 16'h0004);
        heat(12'h0af, 16'h0000);
        // Continuous flag update, then a new boundary with no new conversion
        wr(8'h22, 16'h00b9);
        wr(8'h02, 16'h0028);
        rd_chk(8'h05, 16'h415e);
        $display("test flags done");
    endtask
    task automatic t_lock;
        @(negedge clk_sys_i);
        cls = 1'b1;
        wls = 1'b1;
        @(negedge clk_sys_i);
        cls = 1'b0;
        wls = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk({14'h0000, lc, lw}, 16'h0003);
        wr(8'h04, 16'h0100);
        rd_chk(8'h04, 16'h0190);
        wr(8'h02, 16'h0000);
        rd_chk(8'h02, 16'h0028);
        wr(8'h22, 16'h0000);
        rd_chk(8'h22, 16'h00b9);
        $display("test lock done");
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (10) @(negedge clk_sys_i);
        t_regs();
        t_flags();
        t_lock();
        end_of_test();
    end
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
